// ===== logic/spmsp_defines.svh
// Constants of the serial master/slave port
`ifndef SPMSP_DEFINES_SVH
`define SPMSP_DEFINES_SVH
`define SPMSP_DW 8
`define SPMSP_FIFO_DEPTH 32
`define SPMSP_FIFO_AW 5
`define SPMSP_LAST_BIT 4'h7
`define SPMSP_BITS 4'h8
`define SPMSP_EDGES 5'h10
`define SPMSP_TX_EMPTY_RST 1'b1
`define SPMSP_SEL_RST 1'b1
`define SPMSP_SYNC_SEL_RST 3'h7
`endif

// ===== logic/spmsp_pkg.sv
// Types of the serial master/slave port
`include "spmsp_defines.svh"
package spmsp_pkg;
   // Transfer engine states
   typedef enum logic {
      ST_IDLE = 1'b0,
      ST_XFER = 1'b1
   } spmsp_st_t;
   // Configuration bits
   typedef struct packed {
      logic enable;
      logic master;
      logic clock_polarity;
      logic clock_phase;
      logic lsbf;
      logic bidir;
      logic bidir_oe;
      logic modf_en;
      logic ss_oe;
      logic [2:0] prescale;
      logic [2:0] rate;
   } spmsp_cfg_t;
   // Pin drive: value and enable
   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic mosi_o;
      logic mosi_oe;
      logic miso_o;
      logic miso_oe;
      logic ss_n_o;
      logic ss_n_oe;
   } spmsp_pins_t;
   // Whole state of the port
   typedef struct packed {
      spmsp_st_t st;
      logic [`SPMSP_DW-1:0] sh;
      logic samp;
      logic [3:0] bits;
      logic [4:0] edges;
      logic [2:0] pre_cnt;
      logic [7:0] rate_cnt;
      logic tx_empty;
      logic [`SPMSP_DW-1:0] tx_buf;
      logic rx_full;
      logic [`SPMSP_DW-1:0] rx_buf;
      logic modf;
      logic [2:0] sck_s;
      logic [2:0] mosi_s;
      logic [2:0] miso_s;
      logic [2:0] ss_s;
      logic sck_f;
      logic mosi_f;
      logic miso_f;
      logic ss_f;
      spmsp_pins_t pins;
   } spmsp_state_t;
endpackage

// ===== logic/spmsp_top.sv
// Serial master/slave port with transmit FIFO
//
// Functional notes
// R1: Only master starts transfers; slave follows clock
// R2: Shift out and in together, swap contents
// R3: Far master holds select low while addressing
// R4: Transmit buffer loads shifter at transfer start
// R5: Full byte moves to receive buffer
// R6: Master drives clock, MOSI out, MISO in
// R7: Slave takes clock, MISO out, MOSI in
// R8: Prescaler divides bus clock by 1..8
// R9: Rate divides prescaler by 2..256
// R10: Disabled port drives no pin
// R11: Bidir master uses MOSI, frees MISO
// R12: Bidir slave uses MISO, frees MOSI
// R13: Bidir output enable sets data direction
// R14: Slave always uses select as input
// R15: Master without fault enable frees select
// R16: Fault-enabled master: fault input or select out
// R17: Port inactive in every stop mode
// R18: Deep stop wake comes up in reset
// R19: Light stop holds state unless reset
// R20: Five 8-bit registers worth of control
// R21: Disable aborts, empties, clears flags
// R22: Polarity sets clock idle level
// R23: Phase picks first edge mid or start
// R24: Bit order MSB or LSB first
// R25: Eight master clock pulses then idle
`timescale 1ns/100ps
`include "spmsp_defines.svh"

// Synchronous FIFO with flagged full and empty
module spmsp_fifo #(
   parameter int W = 8,
   parameter int D = 32,
   parameter int AW = 5
) (
   input wire logic clk_i,
   input wire logic arst_n_i,
   input wire logic ce_i,
   input wire logic flush_i,
   input wire logic in_valid_i,
   input wire logic [W-1:0] in_data_i,
   output logic in_ready_o,
   output logic out_valid_o,
   input wire logic out_ready_i,
   output logic [W-1:0] out_data_o
);
   // Pointers, fill level and flags
   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
      logic full;
      logic empty;
   } spmsp_fifo_st_t;
   spmsp_fifo_st_t q; // Registered state
   spmsp_fifo_st_t d; // Next state
   logic [W-1:0] mem [D]; // Storage
   logic push; // Write taken
   logic pop; // Read taken

   assign push = in_valid_i & ~q.full;
   assign pop = out_ready_i & ~q.empty;
   assign in_ready_o = ~q.full;
   assign out_valid_o = ~q.empty;
   assign out_data_o = mem[q.rp];

   // Next pointers and flags
   always_comb begin
      d = q;
      if (flush_i) begin
         d.wp = '0;
         d.rp = '0;
         d.cnt = '0;
      end else begin
         if (push) begin
            d.wp = q.wp + AW'(1);
         end
         if (pop) begin
            d.rp = q.rp + AW'(1);
         end
         d.cnt = q.cnt + (AW+1)'(push) - (AW+1)'(pop);
      end
      d.full = (d.cnt == (AW+1)'(D));
      d.empty = (d.cnt == '0);
   end

   // State register
   always_ff @(posedge clk_i or negedge arst_n_i) begin
      if (!arst_n_i) begin
         q <= '0;
         q.empty <= 1'b1;
      end else if (ce_i) begin
         q <= d;
      end
   end

   // Storage write, no reset needed
   always_ff @(posedge clk_i) begin
      if (ce_i && push && !flush_i) begin
         mem[q.wp] <= in_data_i;
      end
   end
endmodule

// Port top: master/slave shifter, buffers, pin control
module spmsp_top
   import spmsp_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic ARST_N_I,
   input wire logic CLK_EN_I,
   input wire logic STOP_I,
   input wire spmsp_cfg_t CFG_I,
   input wire logic TX_VALID_I,
   input wire logic [`SPMSP_DW-1:0] TX_DATA_I,
   output logic TX_READY_O,
   output logic TX_EMPTY_O,
   output logic RX_FULL_O,
   output logic [`SPMSP_DW-1:0] RX_DATA_O,
   input wire logic RX_READ_I,
   output logic MODF_O,
   input wire logic MODF_CLR_I,
   input wire logic PIN_SCK_I,
   input wire logic PIN_MOSI_I,
   input wire logic PIN_MISO_I,
   input wire logic PIN_SS_N_I,
   output spmsp_pins_t PINS_O
);
   spmsp_cfg_t c; // Configuration alias, control bytes as plain ports [R20]
   spmsp_state_t q; // Registered state
   spmsp_state_t d; // Next state
   logic fifo_valid; // FIFO holds a byte
   logic [`SPMSP_DW-1:0] fifo_data; // FIFO head
   logic fifo_ready; // Buffer can take a byte
   logic fifo_take; // Byte moves to buffer
   logic lead; // Leading clock edge
   logic trail; // Trailing clock edge
   logic tick; // Master half-bit tick
   logic samp_e; // Sampling edge
   logic shift_e; // Shifting edge
   logic run; // Engine may act
   logic mfault; // Mode fault condition
   logic din; // Serial data in
   logic ob; // Serial data out
   logic [7:0] half_lim; // Rate stage limit
   logic [`SPMSP_DW-1:0] exp_rx; // Byte at completion

   assign c = CFG_I;

   // Shift one bit in, direction by bit order [R24]
   function automatic logic [7:0] shf(input logic [7:0] s, input logic b,
                                      input logic lsb);
      shf = lsb ? {b, s[7:1]} : {s[6:0], b};
   endfunction

   // Transmit FIFO ahead of the buffer
   spmsp_fifo #(
      .W(`SPMSP_DW),
      .D(`SPMSP_FIFO_DEPTH),
      .AW(`SPMSP_FIFO_AW)
   ) u_fifo (
      .clk_i(SYS_CLK_I),
      .arst_n_i(ARST_N_I),
      .ce_i(CLK_EN_I),
      .flush_i(~c.enable),
      .in_valid_i(TX_VALID_I),
      .in_data_i(TX_DATA_I),
      .in_ready_o(TX_READY_O),
      .out_valid_o(fifo_valid),
      .out_ready_i(fifo_ready),
      .out_data_o(fifo_data)
   );

   // Buffer pulls from FIFO when empty
   assign fifo_ready = c.enable & ~STOP_I & q.tx_empty;
   assign fifo_take = fifo_valid & fifo_ready;
   // Select pin as fault input [R16]
   assign mfault = c.master & c.modf_en & ~c.ss_oe & ~q.ss_f;
   // Data source per role and pin mode [R6] [R7] [R11] [R12]
   assign din = c.master ? (c.bidir ? q.mosi_f : q.miso_f)
                         : (c.bidir ? q.miso_f : q.mosi_f);
   // Slave acts only while selected [R14]
   assign run = (q.st == ST_XFER) & (c.master ? ~mfault : ~q.ss_f);
   // Half-bit count of prescaled ticks is 2^rate [R9]
   assign half_lim = (8'h01 << c.rate) - 8'h01;
   assign exp_rx = shf(q.sh, din, c.lsbf);

   // Next state of the whole port
   always_comb begin
      d = q;
      lead = 1'b0;
      trail = 1'b0;
      tick = 1'b0;
      ob = 1'b0;
      samp_e = 1'b0;
      shift_e = 1'b0;
      // Three-stage synchronisers
      d.sck_s = {q.sck_s[1:0], PIN_SCK_I};
      d.mosi_s = {q.mosi_s[1:0], PIN_MOSI_I};
      d.miso_s = {q.miso_s[1:0], PIN_MISO_I};
      d.ss_s = {q.ss_s[1:0], PIN_SS_N_I};
      // Accept a level once stages two and three agree
      if (q.sck_s[1] == q.sck_s[2]) begin
         d.sck_f = q.sck_s[2];
      end
      if (q.mosi_s[1] == q.mosi_s[2]) begin
         d.mosi_f = q.mosi_s[2];
      end
      if (q.miso_s[1] == q.miso_s[2]) begin
         d.miso_f = q.miso_s[2];
      end
      if (q.ss_s[1] == q.ss_s[2]) begin
         d.ss_f = q.ss_s[2];
      end
      if (!c.enable) begin
         // Disable aborts and resets the engine [R21]
         d.st = ST_IDLE;
         d.bits = 4'h0;
         d.edges = 5'h00;
         d.pre_cnt = 3'h0;
         d.rate_cnt = 8'h00;
         d.tx_empty = 1'b1;
         d.rx_full = 1'b0;
         d.modf = 1'b0;
      end else if (!STOP_I) begin
         // Software clears first so a new event wins
         if (RX_READ_I) begin
            d.rx_full = 1'b0;
         end
         if (MODF_CLR_I) begin
            d.modf = 1'b0;
         end
         // Buffer the next byte [R4]
         if (fifo_take) begin
            d.tx_empty = 1'b0;
            d.tx_buf = fifo_data;
         end
         if (c.master && mfault) begin
            // Another master drove select low
            d.modf = 1'b1;
            d.st = ST_IDLE;
         end else if (c.master) begin
            unique case (q.st)
               ST_IDLE: begin
                  // Master starts only with a byte waiting [R1] [R4]
                  if (!q.tx_empty) begin
                     d.sh = q.tx_buf;
                     d.tx_empty = 1'b1;
                     d.st = ST_XFER;
                     d.bits = 4'h0;
                     d.edges = 5'h00;
                     d.pre_cnt = 3'h0;
                     d.rate_cnt = 8'h00;
                  end
               end
               ST_XFER: begin
                  // Prescale by setting plus one [R8]
                  if (q.pre_cnt == c.prescale) begin
                     d.pre_cnt = 3'h0;
                     if (q.rate_cnt == half_lim) begin
                        d.rate_cnt = 8'h00;
                        tick = 1'b1;
                     end else begin
                        d.rate_cnt = q.rate_cnt + 8'h01;
                     end
                  end else begin
                     d.pre_cnt = q.pre_cnt + 3'h1;
                  end
                  if (tick) begin
                     // Sixteen edges, then a half bit at idle [R25]
                     if (q.edges == `SPMSP_EDGES) begin
                        d.st = ST_IDLE;
                     end else begin
                        d.edges = q.edges + 5'h01;
                        lead = ~q.edges[0];
                        trail = q.edges[0];
                     end
                  end
               end
            endcase
         end else if (q.ss_f) begin
            // Deselected slave waits [R14]
            d.st = ST_IDLE;
            d.bits = 4'h0;
         end else begin
            // Slave edges come from the pin, polarity undone [R7] [R22]
            lead = (d.sck_f != q.sck_f) & (d.sck_f ^ c.clock_polarity);
            trail = (d.sck_f != q.sck_f) & ~(d.sck_f ^ c.clock_polarity);
            // Load on select (phase 0) or first edge (phase 1) [R4] [R23]
            if (q.st == ST_IDLE && (!c.clock_phase || lead)) begin
               // Only a held byte is consumed, so a byte arriving now survives
               if (!q.tx_empty) begin
                  d.sh = q.tx_buf;
                  d.tx_empty = 1'b1;
               end
               d.st = ST_XFER;
               d.bits = 4'h0;
            end
         end
         // Sample on leading edge for phase 0 [R23]
         samp_e = c.clock_phase ? trail : lead;
         shift_e = c.clock_phase ? lead : trail;
         // Shared shift engine
         if (run) begin
            if (samp_e) begin
               d.samp = din;
               d.bits = q.bits + 4'h1;
               if (q.bits == `SPMSP_LAST_BIT) begin
                  // Completed byte goes to the receive buffer [R2] [R5]
                  d.rx_buf = exp_rx;
                  d.rx_full = 1'b1;
                  if (!c.master && c.clock_phase) begin
                     d.st = ST_IDLE;
                  end
               end
            end
            if (shift_e && q.bits != 4'h0) begin
               if (q.bits == `SPMSP_BITS) begin
                  if (!c.master) begin
                     d.st = ST_IDLE;
                  end
               end else begin
                  d.sh = shf(q.sh, q.samp, c.lsbf); // [R2]
               end
            end
         end
      end
      // Pin drive, released when disabled or stopped [R10] [R17]
      d.pins = '0;
      if (c.enable && !STOP_I) begin
         ob = c.lsbf ? d.sh[0] : d.sh[7];
         if (c.master) begin
            // Clock out, idle at polarity level [R6] [R22]
            d.pins.sck_oe = 1'b1;
            d.pins.sck_o = c.clock_polarity ^ ((d.st == ST_XFER) & d.edges[0]);
            // Bidir: MOSI shared, MISO freed [R11] [R13]
            d.pins.mosi_o = ob;
            d.pins.mosi_oe = c.bidir ? c.bidir_oe : 1'b1;
            // Automatic select output [R15] [R16]
            if (c.modf_en && c.ss_oe) begin
               d.pins.ss_n_oe = 1'b1;
               d.pins.ss_n_o = (d.st != ST_XFER);
            end
         end else begin
            // Slave drives MISO only while selected [R7] [R12] [R13]
            d.pins.miso_o = ob;
            d.pins.miso_oe = ~d.ss_f & (c.bidir ? c.bidir_oe : 1'b1);
         end
      end
   end

   // State register; deep stop wakes via reset [R18] [R19]
   always_ff @(posedge SYS_CLK_I or negedge ARST_N_I) begin
      if (!ARST_N_I) begin
         q <= '0;
         q.tx_empty <= `SPMSP_TX_EMPTY_RST;
         q.ss_s <= `SPMSP_SYNC_SEL_RST;
         q.ss_f <= `SPMSP_SEL_RST;
      end else if (CLK_EN_I) begin
         q <= d;
      end
   end

   // Outputs straight from state
   assign TX_EMPTY_O = q.tx_empty;
   assign RX_FULL_O = q.rx_full;
   assign RX_DATA_O = q.rx_buf;
   assign MODF_O = q.modf;
   assign PINS_O = q.pins;

   // Slave never drives the clock
   a_slave_no_clk: // [R1]
   assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      (CLK_EN_I && !c.master) |=> !PINS_O.sck_oe)
   else $error("slave drives serial clock");

   // Disable empties buffers and releases pins; stop releases pins
   a_disable_clear: // [R21]
   assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      (CLK_EN_I && !c.enable) |=> (TX_EMPTY_O && !RX_FULL_O && !MODF_O))
   else $error("disable left flags set");

   a_disable_pins: // [R10]
   assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      (CLK_EN_I && !c.enable) |=> (PINS_O == '0))
   else $error("disabled port drives a pin");

   a_stop_release: // [R17]
   assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      (CLK_EN_I && STOP_I) |=> (PINS_O == '0) && $stable(RX_DATA_O))
   else $error("port active in stop");

   // Completed byte appears in receive buffer
   a_rx_capture: // [R5]
   assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      (CLK_EN_I && c.enable && !STOP_I && run && samp_e
       && q.bits == `SPMSP_LAST_BIT)
      |=> RX_FULL_O && RX_DATA_O == $past(exp_rx))
   else $error("received byte not captured");

   // Master start moves buffer into shifter
   a_tx_load: // [R4]
   assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      (CLK_EN_I && c.enable && !STOP_I && c.master && !mfault
       && q.st == ST_IDLE && !q.tx_empty)
      |=> q.st == ST_XFER && q.sh == $past(q.tx_buf) && q.edges == 5'h00)
   else $error("buffer not loaded at start");

   // Master edge count bounded, clock idles at polarity
   a_master_edges: // [R25]
   assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      (c.master && q.st == ST_XFER) |-> q.edges <= `SPMSP_EDGES)
   else $error("too many clock edges");

   a_clock_idle: // [R22]
   assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      (CLK_EN_I && c.enable && !STOP_I && c.master && d.st == ST_IDLE)
      |=> PINS_O.sck_oe && PINS_O.sck_o == $past(c.clock_polarity))
   else $error("clock not at idle level");

   // Bidir master and bidir slave each use one data pin
   a_bidir_master: // [R11]
   assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      (CLK_EN_I && c.enable && !STOP_I && c.master && c.bidir)
      |=> !PINS_O.miso_oe && PINS_O.mosi_oe == $past(c.bidir_oe))
   else $error("bidir master pin misuse");

   a_bidir_slave: // [R12]
   assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      (CLK_EN_I && c.enable && !STOP_I && !c.master && c.bidir)
      |=> !PINS_O.mosi_oe && (PINS_O.miso_oe -> $past(c.bidir_oe)))
   else $error("bidir slave pin misuse");

   // Select pin free without fault enable
   a_ss_free: // [R15]
   assert property (@(posedge SYS_CLK_I) disable iff (!ARST_N_I)
      (CLK_EN_I && c.master && !c.modf_en) |=> !PINS_O.ss_n_oe)
   else $error("select pin driven");
endmodule

// ===== test/spmsp_far_slave.sv
// Far-side serial slave model: swaps one byte per eight sample edges
`timescale 1ns/100ps
module spmsp_far_slave (
   input wire logic sck_i,
   input wire logic mosi_i,
   input wire logic ss_n_i,
   input wire logic clock_polarity_i,
   input wire logic clock_phase_i,
   input wire logic lsbf_i,
   input wire logic [7:0] tx_byte_i,
   output logic miso_o,
   output logic miso_oe_o
);
   logic [7:0] sh_q; // Exchange shifter
   int cnt_q; // Bits taken in this byte
   logic [7:0] rx_q[$]; // Bytes taken from the master
   logic lead; // High after a leading clock edge
   assign lead = sck_i ^ clock_polarity_i;
   initial begin
      miso_o = 1'b0;
      miso_oe_o = 1'b0;
      sh_q = 8'h00;
      cnt_q = 0;
   end
   // Fresh byte; phase 0 puts the first bit out at once
   task automatic load();
      sh_q = tx_byte_i;
      cnt_q = 0;
      miso_oe_o = 1'b1;
      if (!clock_phase_i) begin
         miso_o = lsbf_i ? sh_q[0] : sh_q[7];
      end
   endtask
   // Selected: start driving the data line
   always @(negedge ss_n_i) begin
      load();
   end
   // Deselected: line goes back to its pull-up
   always @(posedge ss_n_i) begin
      miso_oe_o = 1'b0;
   end
   // Only the master clock moves bits; sample on one edge, drive on the other
   always @(lead) begin
      if (!ss_n_i) begin
         if (lead ^ clock_phase_i) begin
            sh_q = lsbf_i ? {mosi_i, sh_q[7:1]} : {sh_q[6:0], mosi_i};
            cnt_q++;
            if (cnt_q == 8) begin
               rx_q.push_back(sh_q);
               load();
            end
         end else begin
            miso_o = lsbf_i ? sh_q[0] : sh_q[7];
         end
      end
   end
endmodule

// ===== test/spmsp_top_tb_top.sv
// Self-checking bench for the serial master/slave port
`timescale 1ns/100ps
`define CHK(g, e) begin check_count++; if ((g) !== (e)) begin n_fail++; \
   $display("ERROR t=%0t got=%0h exp=%0h", $time, (g), (e)); end end
module spmsp_top_tb_top;
   import spmsp_pkg::*;
   localparam int LIMIT = 60000; // Cycle ceiling for the run
   logic sys_clk; // Bus clock
   logic arst_n; // Reset, active low
   logic stop; // Stop mode request
   spmsp_cfg_t cfg; // Port configuration
   logic tx_valid; // Write request
   logic [7:0] tx_data; // Write data
   logic rx_read; // Receive read pulse
   logic modf_clr; // Fault clear pulse
   logic tb_ss_n; // Select driven by the bench
   logic tb_sck; // Clock driven by the bench as far master
   logic tb_mosi; // Data driven by the bench as far master
   logic [7:0] far_byte; // Byte the far slave returns
   logic tx_ready;
   logic tx_empty;
   logic rx_full;
   logic modf;
   logic [7:0] rx_data;
   spmsp_pins_t pins;
   logic sck_w;
   logic mosi_w;
   logic miso_w;
   logic ss_w;
   logic far_miso;
   logic far_oe;
   int n_fail;
   int check_count;
   int cyc;
   // Wire levels from all drivers; released lines idle or pulled up
   assign sck_w = pins.sck_oe ? pins.sck_o : (tb_sck ^ cfg.clock_polarity);
   assign mosi_w = pins.mosi_oe ? pins.mosi_o : tb_mosi;
   assign miso_w = pins.miso_oe ? pins.miso_o : (far_oe ? far_miso : 1'b1);
   assign ss_w = pins.ss_n_oe ? pins.ss_n_o : tb_ss_n;
   spmsp_top u_spmsp_top (.SYS_CLK_I(sys_clk), .ARST_N_I(arst_n), .CLK_EN_I(1'b1),
      .STOP_I(stop), .CFG_I(cfg), .TX_VALID_I(tx_valid), .TX_DATA_I(tx_data),
      .TX_READY_O(tx_ready), .TX_EMPTY_O(tx_empty), .RX_FULL_O(rx_full),
      .RX_DATA_O(rx_data), .RX_READ_I(rx_read), .MODF_O(modf), .MODF_CLR_I(modf_clr),
      .PIN_SCK_I(sck_w), .PIN_MOSI_I(mosi_w), .PIN_MISO_I(miso_w), .PIN_SS_N_I(ss_w),
      .PINS_O(pins));
   spmsp_far_slave u_spmsp_far_slave (.sck_i(sck_w), .mosi_i(mosi_w), .ss_n_i(ss_w),
      .clock_polarity_i(cfg.clock_polarity), .clock_phase_i(cfg.clock_phase), .lsbf_i(cfg.lsbf), .tx_byte_i(far_byte),
      .miso_o(far_miso), .miso_oe_o(far_oe));
   // Clock source
   initial begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end
   // Verdict and end of run
   task automatic tally_and_finish();
      $display("checks=%0d mismatches=%0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   // Hang guard
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc >= LIMIT) begin
         n_fail++;
         tally_and_finish();
      end
   end
   // One master byte: rate, clock count, select, exchange, read
   task automatic xfer(input logic cp, input logic ch, input logic lb, input logic [2:0] pr,
      input logic [2:0] rt, input logic [7:0] a, input logic [7:0] b);
      int n;
      int t1;
      int t2;
      int h;
      logic prev;
      logic ss_bad;
      h = (int'(pr) + 1) << rt;
      @(negedge sys_clk);
      cfg.clock_polarity = cp;
      cfg.clock_phase = ch;
      cfg.lsbf = lb;
      cfg.prescale = pr;
      cfg.rate = rt;
      far_byte = b;
      repeat (4) @(negedge sys_clk);
      u_spmsp_far_slave.rx_q.delete();
      tx_valid = 1'b1;
      tx_data = a;
      n = 0;
      t1 = 0;
      t2 = 0;
      ss_bad = 1'b0;
      prev = pins.sck_o;
      for (int i = 0; i < 18 * h + 12; i++) begin
         @(negedge sys_clk);
         tx_valid = 1'b0;
         if (pins.sck_o !== prev) begin
            n++;
            if (n == 1) t1 = i;
            if (n == 2) t2 = i;
         end
         prev = pins.sck_o;
         if (n > 0 && n < 16 && pins.ss_n_o !== 1'b0) ss_bad = 1'b1;
      end
      `CHK(n, 16)
      `CHK(t2 - t1, h)
      `CHK(ss_bad, 1'b0)
      `CHK(pins.sck_o, cp)
      `CHK(rx_full, 1'b1)
      `CHK(rx_data, b)
      `CHK(u_spmsp_far_slave.rx_q[0], a)
      rx_read = 1'b1;
      @(negedge sys_clk);
      rx_read = 1'b0;
      `CHK(rx_full, 1'b0)
   endtask
   // Pin ownership for one setting: {sck, mosi, miso, select} enables
   task automatic pin_role(input logic ms, input logic bd, input logic boe, input logic mf,
      input logic so, input logic ss, input logic st, input logic [3:0] exp);
      @(negedge sys_clk);
      cfg.master = ms;
      cfg.bidir = bd;
      cfg.bidir_oe = boe;
      cfg.modf_en = mf;
      cfg.ss_oe = so;
      tb_ss_n = ss;
      stop = st;
      repeat (8) @(negedge sys_clk);
      `CHK({pins.sck_oe, pins.mosi_oe, pins.miso_oe, pins.ss_n_oe}, exp)
   endtask
   // Far master pulls select low while we are master with fault input
   task automatic mode_fault();
      @(negedge sys_clk);
      cfg.ss_oe = 1'b0;
      tb_ss_n = 1'b0;
      repeat (8) @(negedge sys_clk);
      `CHK(modf, 1'b1)
      `CHK(pins.ss_n_oe, 1'b0)
      tb_ss_n = 1'b1;
      repeat (5) @(negedge sys_clk);
      modf_clr = 1'b1;
      @(negedge sys_clk);
      modf_clr = 1'b0;
      `CHK(modf, 1'b0)
      cfg.ss_oe = 1'b1;
   endtask
   // Disable with one byte received, one shifting and one buffered
   task automatic abort_mid();
      @(negedge sys_clk);
      cfg.prescale = 3'h3;
      cfg.rate = 3'h2;
      tx_valid = 1'b1;
      for (int i = 0; i < 3; i++) begin
         tx_data = 8'h11 * 8'(i + 1);
         @(negedge sys_clk);
      end
      tx_valid = 1'b0;
      for (int i = 0; i < 600 && rx_full !== 1'b1; i++) @(negedge sys_clk);
      repeat (60) @(negedge sys_clk);
      `CHK(tx_empty, 1'b0)
      cfg.enable = 1'b0;
      repeat (4) @(negedge sys_clk);
      `CHK(rx_full, 1'b0)
      `CHK(tx_empty, 1'b1)
      `CHK(pins, 8'h00)
      cfg.enable = 1'b1;
      repeat (400) @(negedge sys_clk);
      `CHK(rx_full, 1'b0)
      `CHK(tx_ready, 1'b1)
   endtask
   // Fill buffer and FIFO while idle as slave, then drain as master
   task automatic fill_drain();
      int n;
      logic ok;
      @(negedge sys_clk);
      cfg.master = 1'b0;
      cfg.prescale = 3'h0;
      cfg.rate = 3'h0;
      tx_valid = 1'b1;
      n = 0;
      for (int i = 0; i < 40; i++) begin
         tx_data = 8'h40 + 8'(n);
         ok = tx_ready;
         @(negedge sys_clk);
         if (ok === 1'b1) n++;
      end
      tx_valid = 1'b0;
      `CHK(n, 33)
      `CHK(tx_ready, 1'b0)
      u_spmsp_far_slave.rx_q.delete();
      cfg.master = 1'b1;
      for (int i = 0; i < 3000 && u_spmsp_far_slave.rx_q.size() < 33; i++) begin
         @(negedge sys_clk);
      end
      for (int i = 0; i < 33; i++) `CHK(u_spmsp_far_slave.rx_q[i], 8'h40 + 8'(i))
      `CHK(tx_empty, 1'b1)
      `CHK(tx_ready, 1'b1)
   endtask
   // Bench as far master clocks one byte through the slave, phase 0, MSB first
   task automatic slave_xfer(input logic [7:0] m, input logic [7:0] s);
      logic [7:0] got;
      @(negedge sys_clk);
      cfg.master = 1'b0;
      cfg.clock_phase = 1'b0;
      cfg.lsbf = 1'b0;
      tb_sck = 1'b0;
      rx_read = 1'b1;
      tx_valid = 1'b1;
      tx_data = s;
      @(negedge sys_clk);
      rx_read = 1'b0;
      tx_valid = 1'b0;
      repeat (4) @(negedge sys_clk);
      tb_ss_n = 1'b0;
      for (int i = 7; i >= 0; i--) begin
         tb_mosi = m[i];
         repeat (8) @(negedge sys_clk);
         got[i] = miso_w;
         tb_sck = 1'b1;
         repeat (8) @(negedge sys_clk);
         tb_sck = 1'b0;
      end
      repeat (8) @(negedge sys_clk);
      tb_ss_n = 1'b1;
      tb_mosi = 1'b1;
      `CHK(got, s)
      `CHK(rx_full, 1'b1)
      `CHK(rx_data, m)
   endtask
   // Main sequence
   initial begin
      n_fail = 0;
      check_count = 0;
      cyc = 0;
      arst_n = 1'b0;
      stop = 1'b0;
      cfg = '0;
      cfg.enable = 1'b1;
      cfg.master = 1'b1;
      cfg.modf_en = 1'b1;
      cfg.ss_oe = 1'b1;
      tx_valid = 1'b0;
      tx_data = 8'h00;
      rx_read = 1'b0;
      modf_clr = 1'b0;
      tb_ss_n = 1'b1;
      tb_sck = 1'b0;
      tb_mosi = 1'b1;
      far_byte = 8'h00;
      repeat (20) @(negedge sys_clk);
      `CHK({pins, tx_empty, rx_full, modf, tx_ready, rx_data}, 20'h0_0900)
      arst_n = 1'b1;
      xfer(1'b0, 1'b0, 1'b0, 3'h3, 3'h2, 8'hA5, 8'h3C);
      xfer(1'b1, 1'b0, 1'b1, 3'h0, 3'h3, 8'h81, 8'h7E);
      xfer(1'b0, 1'b1, 1'b1, 3'h7, 3'h0, 8'hC3, 8'h18);
      xfer(1'b1, 1'b1, 1'b0, 3'h1, 3'h2, 8'h5A, 8'hE1);
      xfer(1'b0, 1'b0, 1'b1, 3'h7, 3'h7, 8'h01, 8'h80);
      pin_role(1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 4'hC);
      pin_role(1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 1'b0, 4'h8);
      pin_role(1'b1, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0, 4'hC);
      pin_role(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 4'hD);
      pin_role(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 4'h0);
      pin_role(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h2);
      pin_role(1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 4'h2);
      pin_role(1'b0, 1'b1, 1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 4'h0);
      pin_role(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 4'h0);
      pin_role(1'b1, 1'b0, 1'b0, 1'b1, 1'b1, 1'b1, 1'b0, 4'hD);
      mode_fault();
      abort_mid();
      fill_drain();
      slave_xfer(8'h96, 8'h4B);
      tally_and_finish();
   end
endmodule
